// file: hdl/core_control.sv
// core control register bank with avalon-mm access
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ns
module core_control (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic loop_enter,
  input wire logic loop_exit,
  input wire logic loop_iteration_end,
  input wire logic priority_top_set,
  input wire logic stack_frame_set,
  input wire logic stack_frame_clear,
  output logic variable_exception_en,
  output logic [1:0] dsp_multiply_sign_select,
  output logic loop_terminate_req,
  output logic [2:0] loop_nesting_depth,
  output logic acc_a_saturate_en,
  output logic acc_b_saturate_en,
  output logic data_write_saturate_en,
  output logic accumulator_saturation_kind,
  output logic priority_top_bit,
  output logic [3:0] cpu_priority_level,
  output logic user_irq_disable,
  output logic frame_stack_full_range,
  output logic rounding_select,
  output logic integer_multiply_mode
);
  import core_control_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // storage
  logic [2:0] priority_lower_bits; // mirror of cpu_flags_register 7:5
  logic nested_interrupt_disable; // locks the lower priority bits
  logic stack_frame_active; // frame status flag
  logic commit_write; // write takes effect this edge
  logic [15:0] read_value; // word selected for read
  logic [2:0] depth; // tracker output

  // byte-lane qualified write strobes per register
  wire sel_ctrl = (address == CORE_CONTROL_OFFSET); // core_control hit
  wire sel_prio = (address == PRIORITY_CONTROL_OFFSET); // priority hit
  wire ctrl_lo = commit_write & sel_ctrl & byteenable[0]; // bits 7:0
  wire ctrl_hi = commit_write & sel_ctrl & byteenable[1]; // bits 15:8
  wire prio_lo = commit_write & sel_prio & byteenable[0]; // bits 7:0
  wire prio_hi = commit_write & sel_prio & byteenable[1]; // bits 15:8

  // loop termination request from software
  wire term_write = ctrl_hi & writedata[LOOP_TERM_POS];
  // lower bits writable only when nesting is allowed
  wire lower_write = prio_lo & ~nested_interrupt_disable;
  // top bit is clear-only from software
  wire top_clear = ctrl_lo & ~writedata[PRIO_TOP_POS];

  ////////////////////////////////////////////////////////////////////////
  // read words
  wire [15:0] ctrl_word = {
    variable_exception_en,
    1'b0, // unimplemented
    dsp_multiply_sign_select,
    1'b0, // loop termination reads zero
    depth,
    acc_a_saturate_en,
    acc_b_saturate_en,
    data_write_saturate_en,
    accumulator_saturation_kind,
    priority_top_bit,
    stack_frame_active,
    rounding_select,
    integer_multiply_mode
  };
  wire [15:0] prio_word = {
    nested_interrupt_disable,
    7'h00,
    priority_lower_bits,
    5'h00
  };
  // unmapped addresses read zero
  assign read_value = sel_ctrl ? ctrl_word : (sel_prio ? prio_word : 16'h0000);

  ////////////////////////////////////////////////////////////////////////
  // bus slave
  avmm_wait_slave u_slave (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .read(read),
    .write(write),
    .read_value(read_value),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .commit_write(commit_write)
  );

  ////////////////////////////////////////////////////////////////////////
  // loop nesting counter
  loop_depth_tracker u_depth (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .loop_enter(loop_enter),
    .loop_exit(loop_exit),
    .depth(depth)
  );
  assign loop_nesting_depth = depth;

  ////////////////////////////////////////////////////////////////////////
  // upper byte of core_control
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      variable_exception_en <= CORE_CONTROL_RESET[VAR_EXC_POS];
      dsp_multiply_sign_select <= CORE_CONTROL_RESET[SIGN_SEL_LSB +: 2];
    end else if (ctrl_hi) begin
      variable_exception_en <= writedata[VAR_EXC_POS];
      dsp_multiply_sign_select <= writedata[SIGN_SEL_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lower byte of core_control, plain read/write fields
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_a_saturate_en <= CORE_CONTROL_RESET[ACC_A_SAT_POS];
      acc_b_saturate_en <= CORE_CONTROL_RESET[ACC_B_SAT_POS];
      data_write_saturate_en <= CORE_CONTROL_RESET[DATA_WR_SAT_POS];
      accumulator_saturation_kind <= CORE_CONTROL_RESET[SAT_KIND_POS];
      rounding_select <= CORE_CONTROL_RESET[ROUND_SEL_POS];
      integer_multiply_mode <= CORE_CONTROL_RESET[MUL_MODE_POS];
    end else if (ctrl_lo) begin
      acc_a_saturate_en <= writedata[ACC_A_SAT_POS];
      acc_b_saturate_en <= writedata[ACC_B_SAT_POS];
      data_write_saturate_en <= writedata[DATA_WR_SAT_POS];
      accumulator_saturation_kind <= writedata[SAT_KIND_POS];
      rounding_select <= writedata[ROUND_SEL_POS];
      integer_multiply_mode <= writedata[MUL_MODE_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // loop termination request, held until the iteration ends or the depth reaches zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      loop_terminate_req <= 1'b0;
    end else if (term_write && depth != 3'h0) begin
      loop_terminate_req <= 1'b1; // set wins over the clear
    end else if (loop_iteration_end || depth == 3'h0) begin
      loop_terminate_req <= 1'b0; // iteration done or no loop left
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // priority top bit: hardware sets, software clears
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      priority_top_bit <= CORE_CONTROL_RESET[PRIO_TOP_POS];
    end else if (priority_top_set) begin
      priority_top_bit <= 1'b1; // set wins over clear
    end else if (top_clear) begin
      priority_top_bit <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stack frame flag, read-only to software
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stack_frame_active <= CORE_CONTROL_RESET[FRAME_ACTIVE_POS];
    end else if (stack_frame_set) begin
      stack_frame_active <= 1'b1;
    end else if (stack_frame_clear) begin
      stack_frame_active <= 1'b0;
    end
  end
  // full range ignores the read page; clear keeps base space
  assign frame_stack_full_range = stack_frame_active;

  ////////////////////////////////////////////////////////////////////////
  // priority_control register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      priority_lower_bits <= PRIORITY_CONTROL_RESET[PRIO_LOWER_LSB +: 3];
      nested_interrupt_disable <= PRIORITY_CONTROL_RESET[NEST_DIS_POS];
    end else begin
      if (lower_write) begin
        priority_lower_bits <= writedata[PRIO_LOWER_LSB +: 3];
      end
      if (prio_hi) begin
        nested_interrupt_disable <= writedata[NEST_DIS_POS];
      end
    end
  end

  // level is top bit above the three lower bits
  assign cpu_priority_level = {priority_top_bit, priority_lower_bits};
  // levels eight and up shut out user interrupts
  assign user_irq_disable = priority_top_bit;

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_term_reads_zero;
    @(posedge core_clk) disable iff (!rst_b)
    (!waitrequest && read) |-> readdata[11] == 1'b0;
  endproperty
  a_term_reads_zero: assert property (p_term_reads_zero)
    else $error("termination bit read as one");

  property p_term_set;
    @(posedge core_clk) disable iff (!rst_b)
    (commit_write && sel_ctrl && byteenable[1] && writedata[11] && depth != 3'h0)
      |=> loop_terminate_req;
  endproperty
  a_term_set: assert property (p_term_set)
    else $error("termination not requested");

  property p_term_zero_no_effect;
    @(posedge core_clk) disable iff (!rst_b)
    (!loop_terminate_req && !(commit_write && sel_ctrl && writedata[11]))
      |=> !loop_terminate_req;
  endproperty
  a_term_zero_no_effect: assert property (p_term_zero_no_effect)
    else $error("termination rose without a one write");

  property p_level_join;
    @(posedge core_clk) disable iff (!rst_b)
    lower_write |=> cpu_priority_level[2:0] == $past(writedata[7:5]);
  endproperty
  a_level_join: assert property (p_level_join)
    else $error("priority level does not hold the written bits");

  property p_lower_locked;
    @(posedge core_clk) disable iff (!rst_b)
    nested_interrupt_disable |=> $stable(cpu_priority_level[2:0]);
  endproperty
  a_lower_locked: assert property (p_lower_locked)
    else $error("locked priority bits changed");

  // hardware set lifts the level to eight and up and gates user interrupts
  property p_user_irq;
    @(posedge core_clk) disable iff (!rst_b)
    priority_top_set |=> user_irq_disable && cpu_priority_level[3];
  endproperty
  a_user_irq: assert property (p_user_irq)
    else $error("user interrupt gate wrong for level");

  property p_round_sel;
    @(posedge core_clk) disable iff (!rst_b)
    ctrl_lo |=> rounding_select == $past(writedata[ROUND_SEL_POS]);
  endproperty
  a_round_sel: assert property (p_round_sel)
    else $error("rounding select not taken");

  property p_mul_mode;
    @(posedge core_clk) disable iff (!rst_b)
    ctrl_lo |=> integer_multiply_mode == $past(writedata[0]);
  endproperty
  a_mul_mode: assert property (p_mul_mode)
    else $error("multiply mode not taken");

  property p_frame_range;
    @(posedge core_clk) disable iff (!rst_b)
    (stack_frame_set |=> frame_stack_full_range)
      and (stack_frame_clear && !stack_frame_set |=> !frame_stack_full_range);
  endproperty
  a_frame_range: assert property (p_frame_range)
    else $error("frame range flag wrong");

  // software writes never move the frame flag
  property p_frame_ro;
    @(posedge core_clk) disable iff (!rst_b)
    (!stack_frame_set && !stack_frame_clear) |=> $stable(stack_frame_active);
  endproperty
  a_frame_ro: assert property (p_frame_ro)
    else $error("frame flag moved without a hardware pulse");

  // a zero write clears the top bit unless hardware sets it
  property p_top_clear;
    @(posedge core_clk) disable iff (!rst_b)
    (top_clear && !priority_top_set) |=> !priority_top_bit && !user_irq_disable;
  endproperty
  a_top_clear: assert property (p_top_clear)
    else $error("top priority bit not cleared");

  // pending termination drops at the iteration boundary
  property p_term_clears;
    @(posedge core_clk) disable iff (!rst_b)
    (loop_terminate_req && loop_iteration_end && !term_write) |=> !loop_terminate_req;
  endproperty
  a_term_clears: assert property (p_term_clears)
    else $error("termination held past the iteration end");

  // a locked write leaves the lower bits alone
  property p_lower_write_blocked;
    @(posedge core_clk) disable iff (!rst_b)
    (prio_lo && nested_interrupt_disable) |=> $stable(priority_lower_bits);
  endproperty
  a_lower_write_blocked: assert property (p_lower_write_blocked)
    else $error("locked priority bits took a write");

  // the bus acknowledge lasts a single cycle
  property p_ack_one_cycle;
    @(posedge core_clk) disable iff (!rst_b)
    !waitrequest |=> waitrequest;
  endproperty
  a_ack_one_cycle: assert property (p_ack_one_cycle)
    else $error("waitrequest low for more than one cycle");
endmodule // core_control

// file: hdl/core_control_pkg.sv
// constants for the core control register bank
package core_control_pkg;
  // register byte offsets on the avalon slave
  localparam logic [3:0] CORE_CONTROL_OFFSET = 4'h0;
  localparam logic [3:0] PRIORITY_CONTROL_OFFSET = 4'h4;
  // core_control field positions
  localparam int VAR_EXC_POS = 15;
  localparam int SIGN_SEL_LSB = 12;
  localparam int LOOP_TERM_POS = 11;
  localparam int DEPTH_LSB = 8;
  localparam int ACC_A_SAT_POS = 7;
  localparam int ACC_B_SAT_POS = 6;
  localparam int DATA_WR_SAT_POS = 5;
  localparam int SAT_KIND_POS = 4;
  localparam int PRIO_TOP_POS = 3;
  localparam int FRAME_ACTIVE_POS = 2;
  localparam int ROUND_SEL_POS = 1;
  localparam int MUL_MODE_POS = 0;
  // priority_control field positions
  localparam int PRIO_LOWER_LSB = 5;
  localparam int NEST_DIS_POS = 15;
  // reset values
  localparam logic [15:0] CORE_CONTROL_RESET = 16'h0020;
  localparam logic [15:0] PRIORITY_CONTROL_RESET = 16'h0000;
  // loop depth limit
  localparam logic [2:0] DEPTH_MAX = 3'h7;
  // avalon slave handshake states
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_ack = 2'b10
  } slave_state_e;
endpackage

// file: hdl/avmm_wait_slave.sv
// avalon-mm slave handshake with one wait state
`timescale 1ns/1ns
module avmm_wait_slave (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic read,
  input wire logic write,
  input wire logic [15:0] read_value,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic commit_write
);
  import core_control_pkg::*;

  slave_state_e state; // handshake state
  slave_state_e next_state; // next handshake state
  wire request = read | write; // any access pending

  // idle -> ack on a request, ack -> idle always
  assign next_state = (state == st_idle && request) ? st_ack : st_idle;
  // a write lands at the edge where waitrequest is sampled low
  assign commit_write = write & ~waitrequest;

  ////////////////////////////////////////////////////////////////////////
  // state, waitrequest and read data flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= st_idle;
      waitrequest <= 1'b1;
      readdata <= 32'h0;
    end else begin
      state <= next_state;
      waitrequest <= ~(next_state == st_ack); // low only in the ack cycle
      if (state == st_idle && request) begin
        readdata <= {16'h0, read_value}; // upper half reads zero
      end
    end
  end
endmodule // avmm_wait_slave

// file: hdl/loop_depth_tracker.sv
// active hardware loop nesting counter
`timescale 1ns/1ns
module loop_depth_tracker (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic loop_enter,
  input wire logic loop_exit,
  output logic [2:0] depth
);
  import core_control_pkg::*;

  wire go_up = loop_enter & ~loop_exit & (depth != DEPTH_MAX); // entry only
  wire go_down = loop_exit & ~loop_enter & (depth != 3'h0); // exit only
  logic [2:0] next_depth; // depth after this cycle

  // saturating step; enter and exit together cancel
  assign next_depth = go_up ? 3'(depth + 3'h1) :
                      go_down ? 3'(depth - 3'h1) : depth;

  ////////////////////////////////////////////////////////////////////////
  // depth register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      depth <= 3'h0;
    end else begin
      depth <= next_depth;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_depth_up;
    @(posedge core_clk) disable iff (!rst_b)
    (loop_enter && !loop_exit && depth != 3'h7) |=> depth == 3'($past(depth) + 3'h1);
  endproperty
  a_depth_up: assert property (p_depth_up) else $error("depth did not rise");

  property p_depth_down;
    @(posedge core_clk) disable iff (!rst_b)
    (loop_exit && !loop_enter && depth != 3'h0) |=> depth == 3'($past(depth) - 3'h1);
  endproperty
  a_depth_down: assert property (p_depth_down) else $error("depth did not fall");
endmodule // loop_depth_tracker

// file: dv/test_core_control.sv
// self-checking bench for the core control register bank
`timescale 1ns/1ns
module test_core_control;
  import core_control_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // clock, reset and design ports
  logic core_clk = 1'b0; // 50 mhz core clock
  logic rst_b = 1'b0; // async reset, active low
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [5:0] ev = 6'h0; // enter, exit, iter end, top set, frame set, frame clear
  logic loop_enter, loop_exit, loop_iteration_end;
  logic priority_top_set, stack_frame_set, stack_frame_clear;
  logic variable_exception_en, loop_terminate_req, acc_a_saturate_en, acc_b_saturate_en;
  logic data_write_saturate_en, accumulator_saturation_kind, priority_top_bit;
  logic user_irq_disable, frame_stack_full_range, rounding_select, integer_multiply_mode;
  logic [1:0] dsp_multiply_sign_select;
  logic [2:0] loop_nesting_depth;
  logic [3:0] cpu_priority_level;
  logic [31:0] exp_q[$]; // expected read data, oldest first
  int errors = 0;
  int checks = 0;
  logic [15:0] w; // random write value
  logic [2:0] lo; // random lower priority bits
  assign {loop_enter, loop_exit, loop_iteration_end} = ev[5:3];
  assign {priority_top_set, stack_frame_set, stack_frame_clear} = ev[2:0];
  // clock toggles every half period
  always #10 core_clk = ~core_clk;
  core_control dut (.core_clk(core_clk), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .loop_enter(loop_enter), .loop_exit(loop_exit),
    .loop_iteration_end(loop_iteration_end), .priority_top_set(priority_top_set),
    .stack_frame_set(stack_frame_set), .stack_frame_clear(stack_frame_clear),
    .variable_exception_en(variable_exception_en),
    .dsp_multiply_sign_select(dsp_multiply_sign_select),
    .loop_terminate_req(loop_terminate_req), .loop_nesting_depth(loop_nesting_depth),
    .acc_a_saturate_en(acc_a_saturate_en), .acc_b_saturate_en(acc_b_saturate_en),
    .data_write_saturate_en(data_write_saturate_en),
    .accumulator_saturation_kind(accumulator_saturation_kind),
    .priority_top_bit(priority_top_bit), .cpu_priority_level(cpu_priority_level),
    .user_irq_disable(user_irq_disable), .frame_stack_full_range(frame_stack_full_range),
    .rounding_select(rounding_select), .integer_multiply_mode(integer_multiply_mode));
  ////////////////////////////////////////////////////////////////////////
  // comparison and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    // case inequality so unknowns never match
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // avalon master: hold request until waitrequest is seen low at an edge
  task automatic bus(input logic rd, input logic [3:0] a, input logic [15:0] d,
                     input logic [3:0] be, input logic [15:0] exp);
    @(posedge core_clk);
    address <= a;
    read <= rd;
    write <= ~rd;
    writedata <= {16'h0, d};
    byteenable <= be;
    if (rd) begin
      exp_q.push_back({16'h0, exp});
    end
    // hold everything until waitrequest is sampled low at a rising edge
    do begin
      @(posedge core_clk);
    end while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus(1'b0, a, d, 4'h3, 16'h0);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    bus(1'b1, a, 16'h0, 4'h3, exp);
  endtask
  // one-cycle hardware event pulse, outputs settled on return
  task automatic pulse(input logic [5:0] v);
    @(posedge core_clk);
    ev <= v;
    @(posedge core_clk);
    ev <= 6'h0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watcher: each accepted read takes the oldest expectation
  always @(posedge core_clk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("unexpected at %0t: read with no expectation", $time);
      end else begin
        check(readdata, exp_q.pop_front());
      end
    end
  end
  // watchdog, far beyond the roughly 150 cycles of the run
  initial begin
    #400000;
    errors++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32045));
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    // reset values and unmapped space
    rd(CORE_CONTROL_OFFSET, CORE_CONTROL_RESET);
    rd(PRIORITY_CONTROL_OFFSET, 16'h0000);
    rd(4'h8, 16'h0000);
    // random writes: writable bits stored, bit 11 reads zero, ro bits kept
    repeat (4) begin
      w = 16'($urandom);
      wr(CORE_CONTROL_OFFSET, w);
      #1;
      check(32'(loop_terminate_req), 32'h0);
      check(32'({variable_exception_en, dsp_multiply_sign_select, acc_a_saturate_en,
        acc_b_saturate_en, data_write_saturate_en, accumulator_saturation_kind,
        rounding_select, integer_multiply_mode}), 32'({w[15], w[13:12], w[7:4], w[1:0]}));
      rd(CORE_CONTROL_OFFSET, w & 16'hb0f3);
    end
    // upper lane only, then an ignored unmapped write
    bus(1'b0, CORE_CONTROL_OFFSET, 16'hffff, 4'h2, 16'h0);
    wr(4'h8, 16'h0000);
    rd(CORE_CONTROL_OFFSET, 16'hb000 | (w & 16'h00f3));
    wr(CORE_CONTROL_OFFSET, 16'h0000);
    // depth saturates at seven, then six exits bring it down to one
    repeat (8) pulse(6'h20);
    check(32'(loop_nesting_depth), 32'(DEPTH_MAX));
    rd(CORE_CONTROL_OFFSET, 16'h0700);
    repeat (6) pulse(6'h10);
    check(32'(loop_nesting_depth), 32'h1);
    // early termination request ends at the iteration boundary
    wr(CORE_CONTROL_OFFSET, 16'h0800);
    #1;
    check(32'(loop_terminate_req), 32'h1);
    rd(CORE_CONTROL_OFFSET, 16'h0100);
    pulse(6'h08);
    check(32'(loop_terminate_req), 32'h0);
    wr(CORE_CONTROL_OFFSET, 16'h0000);
    #1;
    check(32'(loop_terminate_req), 32'h0);
    repeat (2) pulse(6'h10);
    check(32'(loop_nesting_depth), 32'h0);
    // priority level joins top bit with lower bits
    lo = 3'($urandom_range(7, 0));
    wr(PRIORITY_CONTROL_OFFSET, {8'h0, lo, 5'h0});
    #1;
    check(32'(cpu_priority_level), 32'({1'b0, lo}));
    pulse(6'h04);
    check(32'({priority_top_bit, user_irq_disable, cpu_priority_level}),
      32'({2'b11, 1'b1, lo}));
    wr(CORE_CONTROL_OFFSET, 16'h0008);
    rd(CORE_CONTROL_OFFSET, 16'h0008);
    wr(CORE_CONTROL_OFFSET, 16'h0000);
    #1;
    check(32'({priority_top_bit, user_irq_disable}), 32'h0);
    // lower bits locked while nesting is disabled
    wr(PRIORITY_CONTROL_OFFSET, {1'b1, 7'h0, lo, 5'h0});
    wr(PRIORITY_CONTROL_OFFSET, {1'b1, 7'h0, ~lo, 5'h0});
    rd(PRIORITY_CONTROL_OFFSET, {1'b1, 7'h0, lo, 5'h0});
    check(32'(cpu_priority_level), 32'({1'b0, lo}));
    // frame flag: hardware only, set wins over clear
    pulse(6'h02);
    check(32'(frame_stack_full_range), 32'h1);
    wr(CORE_CONTROL_OFFSET, 16'h0000);
    rd(CORE_CONTROL_OFFSET, 16'h0004);
    pulse(6'h01);
    check(32'(frame_stack_full_range), 32'h0);
    pulse(6'h03);
    check(32'(frame_stack_full_range), 32'h1);
    pulse(6'h01);
    check(32'(frame_stack_full_range), 32'h0);
    repeat (2) @(posedge core_clk);
    if (exp_q.size() != 0) begin
      errors++;
      $display("unexpected at %0t: reads left unanswered", $time);
    end
    test_done();
  end
endmodule // test_core_control
